// ==== include/otss_pkg.sv ====
// package: register map, function codes, status-word layout for the output terminal selector
//---------------------------------------------------------------------------
// Overview of operation
// - two terminals; first selector 0..82, default 33
// - second selector 0..82, default 2
// - selector write reaches the terminal at the next evaluation tick
// - shared inversion mask 0..FFF, default 0
// - terminal states readable in diagnostic register
// - each signal on terminal or status bit
// - signals non-inverted; inversion gives complement
// - signal valid only in its marked modes
// - status bits addressed as word plus bit
// - fn6 temp pre-warning bit7; fn37 bit10
// - fn11-14 motor selected, speed mode only
// - fn15-18 fixed setpoint number bits 0-3
// - fn28 spindle positioning, first word bit15
// - fn35 open brake, second word bit5
// - integrator inhibit, torque mode: status bits only
//---------------------------------------------------------------------------
package otss_pkg;

   // register word addresses (byte offsets)
   localparam logic [7:0]  ADDR_SEL0     = 8'h00;
   localparam logic [7:0]  ADDR_SEL1     = 8'h04;
   localparam logic [7:0]  ADDR_INV      = 8'h08;
   localparam logic [7:0]  ADDR_READBACK = 8'h0C;
   localparam logic [7:0]  ADDR_MODE     = 8'h10;
   localparam logic [7:0]  ADDR_SIGW     = 8'h14;
   localparam logic [7:0]  ADDR_STW1     = 8'h18;
   localparam logic [7:0]  ADDR_STW2     = 8'h1C;
   localparam logic [7:0]  ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0]  ADDR_IRQ_MASK = 8'h24;
   localparam logic [7:0]  ADDR_FB_OUT   = 8'h28;

   localparam logic [15:0] SEL0_RESET    = 16'h0021;
   localparam logic [15:0] SEL1_RESET    = 16'h0002;
   localparam logic [15:0] INV_RESET     = 16'h0000;
   localparam logic [15:0] SEL_MAX       = 16'h0052;
   localparam logic [15:0] INV_MAX       = 16'h0FFF;
   localparam logic [1:0]  MODE_RESET    = 2'h0;

   // evaluation tick: 1 us at 100 MHz
   localparam int          CLK_MHZ       = 100;
   localparam int          TICK_US       = 1;
   localparam int          TICK_CYCLES   = TICK_US * CLK_MHZ;

   // interrupt status bits
   localparam int          IRQ_T0_CHG    = 0;
   localparam int          IRQ_T1_CHG    = 1;
   localparam int          IRQ_BAD_WR    = 2;

   // signalling word bits
   localparam int SIGW_RAMP   = 0;
   localparam int SIGW_TRQ    = 1;
   localparam int SIGW_NMIN   = 2;
   localparam int SIGW_NX     = 3;
   localparam int SIGW_VDC    = 4;
   localparam int SIGW_VAR    = 5;
   localparam int SIGW_MOTT   = 6;
   localparam int SIGW_PMT    = 7;
   localparam int SIGW_NSETACT = 8;
   localparam int SIGW_PMI    = 10;
   localparam int SIGW_PULSE  = 13;
   // first status word bits
   localparam int STW1_RDY    = 1;
   localparam int STW1_CEN    = 2;
   localparam int STW1_FLT    = 3;
   localparam int STW1_WARN   = 7;
   localparam int STW1_OLT    = 14;
   localparam int STW1_SPOS   = 15;
   // second status word bits
   localparam int STW2_BRAKE  = 5;
   localparam int STW2_INTINH = 6;
   localparam int STW2_PARK   = 7;

   // operating modes
   typedef enum logic [1:0] {
      MODE_NSET = 2'h0,
      MODE_POS  = 2'h1
   } otss_mode_e;

   // internal drive status inputs
   typedef struct packed {
      logic       nact_lt_nmin;
      logic       ramp_done;
      logic       torque_lt_mx;
      logic       nact_lt_nx;
      logic       motor_ot_warn;
      logic       pm_temp_warn;
      logic       var_signal;
      logic       open_loop_torque;
      logic       int_inhibit;
      logic [1:0] motor_sel;
      logic [3:0] fixed_setpoint;
      logic       nset_eq_nact;
      logic       spindle_pos_on;
      logic       warning;
      logic       vdc_gt_vx;
      logic       fault_free;
      logic       ctrl_enable;
      logic       ready;
      logic       parking_axis;
      logic       open_brake;
      logic       pulses_enabled;
      logic       pm_current_ok;
   } otss_status_s;

   typedef struct packed {
      logic       cyc;
      logic       stb;
      logic       we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } otss_wb_req_s;

endpackage

// ==== rtl/otss_top.sv ====
// output terminal selector: wishbone registers, function mux, inversion, terminal drive
`timescale 1ns/1ps
module otss_top (
   input  wire logic                  MCLK,
   input  wire logic                  RESET,
   input  wire logic                  WB_CYC_I,
   input  wire logic                  WB_STB_I,
   input  wire logic                  WB_WE_I,
   input  wire logic [3:0]            WB_SEL_I,
   input  wire logic [7:0]            WB_ADR_I,
   input  wire logic [31:0]           WB_DAT_I,
   output logic      [31:0]           WB_DAT_O,
   output logic                       WB_ACK_O,
   input  wire otss_pkg::otss_status_s STATUS_IN,
   output logic                       FIRST_OUTPUT_TERMINAL,
   output logic                       SECOND_OUTPUT_TERMINAL,
   output logic                       IRQ
);

   //------------------------------------------------------------------------
   // registers
   //------------------------------------------------------------------------
   logic [15:0] sel0_q;
   logic [15:0] sel1_q;
   logic [15:0] inv_q;
   logic [1:0]  mode_q;
   logic        fb_out_q;
   logic [2:0]  irq_stat_q;
   logic [2:0]  irq_mask_q;
   logic        ack_q;
   logic [31:0] rdat_q;
   logic [1:0]  term_q;
   logic [6:0]  tick_cnt_q;
   logic        tick;
   logic        wr_en;
   logic        rd_en;
   logic [15:0] wdat16;
   logic        bad_wr;
   logic [15:0] sigw;
   logic [15:0] stw1;
   logic [15:0] stw2;
   logic [1:0]  term_d;
   logic [2:0]  irq_set;

   assign wr_en  = WB_CYC_I & WB_STB_I & WB_WE_I & ~ack_q;
   assign rd_en  = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~ack_q;
   assign wdat16 = {WB_SEL_I[1] ? WB_DAT_I[15:8] : 8'h00, WB_SEL_I[0] ? WB_DAT_I[7:0] : 8'h00};

   //------------------------------------------------------------------------
   // function decode
   //------------------------------------------------------------------------
   // returns selected signal, already gated by mode validity
   function automatic logic fn_select(input logic [15:0] fn,
                                      input otss_pkg::otss_status_s s,
                                      input logic [1:0] mode,
                                      input logic fb);
      logic nset;
      logic v;
      nset = (mode == otss_pkg::MODE_NSET);
      v    = 1'b0;
      unique case (fn)
         16'h0000: v = 1'b0;
         16'h0001: v = s.nact_lt_nmin;
         16'h0002: v = s.ramp_done;
         16'h0003: v = s.torque_lt_mx;
         16'h0004: v = s.nact_lt_nx;
         16'h0005: v = s.motor_ot_warn;
         16'h0006: v = s.pm_temp_warn;
         16'h0007: v = s.var_signal;
         // speed-mode only functions forced low in positioning mode
         16'h000B: v = nset & (s.motor_sel == 2'h0);
         16'h000C: v = nset & (s.motor_sel == 2'h1);
         16'h000D: v = nset & (s.motor_sel == 2'h2);
         16'h000E: v = nset & (s.motor_sel == 2'h3);
         16'h000F: v = nset & s.fixed_setpoint[0];
         16'h0010: v = nset & s.fixed_setpoint[1];
         16'h0011: v = nset & s.fixed_setpoint[2];
         16'h0012: v = nset & s.fixed_setpoint[3];
         16'h0014: v = s.nset_eq_nact;
         16'h001C: v = nset & s.spindle_pos_on;
         16'h001D: v = s.warning;
         16'h001E: v = s.vdc_gt_vx;
         16'h001F: v = s.fault_free;
         16'h0020: v = s.ctrl_enable;
         16'h0021: v = s.ready;
         16'h0022: v = s.parking_axis;
         16'h0023: v = s.open_brake;
         16'h0024: v = s.pulses_enabled;
         16'h0025: v = s.pm_current_ok;
         16'h0026: v = fb;
         // unlisted codes drive inactive
         default:  v = 1'b0;
      endcase
      return v;
   endfunction

   // word name plus bit index layout
   always_comb begin
      sigw = 16'h0000;
      stw1 = 16'h0000;
      stw2 = 16'h0000;
      sigw[otss_pkg::SIGW_RAMP]    = STATUS_IN.ramp_done;
      sigw[otss_pkg::SIGW_TRQ]     = STATUS_IN.torque_lt_mx;
      sigw[otss_pkg::SIGW_NMIN]    = STATUS_IN.nact_lt_nmin;
      sigw[otss_pkg::SIGW_NX]      = STATUS_IN.nact_lt_nx;
      sigw[otss_pkg::SIGW_VDC]     = STATUS_IN.vdc_gt_vx;
      sigw[otss_pkg::SIGW_VAR]     = STATUS_IN.var_signal;
      sigw[otss_pkg::SIGW_MOTT]    = STATUS_IN.motor_ot_warn;
      sigw[otss_pkg::SIGW_PMT]     = STATUS_IN.pm_temp_warn;
      sigw[otss_pkg::SIGW_NSETACT] = STATUS_IN.nset_eq_nact;
      sigw[otss_pkg::SIGW_PMI]     = STATUS_IN.pm_current_ok;
      sigw[otss_pkg::SIGW_PULSE]   = STATUS_IN.pulses_enabled;
      stw1[otss_pkg::STW1_RDY]     = STATUS_IN.ready;
      stw1[otss_pkg::STW1_CEN]     = STATUS_IN.ctrl_enable;
      stw1[otss_pkg::STW1_FLT]     = STATUS_IN.fault_free;
      stw1[otss_pkg::STW1_WARN]    = STATUS_IN.warning;
      stw1[otss_pkg::STW1_OLT]     = STATUS_IN.open_loop_torque;
      stw1[otss_pkg::STW1_SPOS]    = (mode_q == otss_pkg::MODE_NSET) & STATUS_IN.spindle_pos_on;
      stw2[otss_pkg::STW2_BRAKE]   = STATUS_IN.open_brake;
      stw2[otss_pkg::STW2_INTINH]  = STATUS_IN.int_inhibit;
      stw2[otss_pkg::STW2_PARK]    = STATUS_IN.parking_axis;
   end

   //------------------------------------------------------------------------
   // evaluation tick
   //------------------------------------------------------------------------
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         tick_cnt_q <= 7'h00;
      end else if (tick) begin
         tick_cnt_q <= 7'h00;
      end else begin
         tick_cnt_q <= tick_cnt_q + 7'h01;
      end
   end
   assign tick = (tick_cnt_q == 7'(otss_pkg::TICK_CYCLES - 1));

   //------------------------------------------------------------------------
   // terminal drive
   //------------------------------------------------------------------------
   // inversion bit 0 -> first terminal, bit 1 -> second; upper mask bits stored only
   assign term_d[0] = fn_select(sel0_q, STATUS_IN, mode_q, fb_out_q) ^ inv_q[0];
   assign term_d[1] = fn_select(sel1_q, STATUS_IN, mode_q, fb_out_q) ^ inv_q[1];

   // status is asynchronous drive state; the tick register resolves it once per period
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         term_q <= 2'h0;
      end else if (tick) begin
         term_q <= term_d;
      end
   end
   assign FIRST_OUTPUT_TERMINAL  = term_q[0];
   assign SECOND_OUTPUT_TERMINAL = term_q[1];

   //------------------------------------------------------------------------
   // configuration registers
   //------------------------------------------------------------------------
   // out-of-range values rejected; config assumed changed with pulses cancelled
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         sel0_q <= otss_pkg::SEL0_RESET;
         sel1_q <= otss_pkg::SEL1_RESET;
         inv_q  <= otss_pkg::INV_RESET;
         mode_q <= otss_pkg::MODE_RESET;
         fb_out_q <= 1'b0;
      end else if (wr_en && !bad_wr) begin
         unique case (WB_ADR_I)
            otss_pkg::ADDR_SEL0:   sel0_q <= wdat16;
            otss_pkg::ADDR_SEL1:   sel1_q <= wdat16;
            otss_pkg::ADDR_INV:    inv_q  <= wdat16;
            otss_pkg::ADDR_MODE:   mode_q <= wdat16[1:0];
            otss_pkg::ADDR_FB_OUT: fb_out_q <= wdat16[0];
            default: ;
         endcase
      end
   end

   always_comb begin
      bad_wr = 1'b0;
      if (wr_en) begin
         unique case (WB_ADR_I)
            otss_pkg::ADDR_SEL0, otss_pkg::ADDR_SEL1: bad_wr = (wdat16 > otss_pkg::SEL_MAX);
            otss_pkg::ADDR_INV:  bad_wr = (wdat16 > otss_pkg::INV_MAX);
            otss_pkg::ADDR_MODE: bad_wr = (wdat16 > 16'h0001);
            default:             bad_wr = 1'b0;
         endcase
      end
   end

   //------------------------------------------------------------------------
   // interrupts
   //------------------------------------------------------------------------
   assign irq_set = {bad_wr, tick & (term_d[1] != term_q[1]), tick & (term_d[0] != term_q[0])};

   // set wins over write-one-to-clear
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         irq_stat_q <= 3'h0;
         irq_mask_q <= 3'h0;
      end else begin
         if (wr_en && WB_ADR_I == otss_pkg::ADDR_IRQ_MASK && WB_SEL_I[0]) begin
            irq_mask_q <= WB_DAT_I[2:0];
         end
         if (wr_en && WB_ADR_I == otss_pkg::ADDR_IRQ_STAT && WB_SEL_I[0]) begin
            irq_stat_q <= (irq_stat_q & ~WB_DAT_I[2:0]) | irq_set;
         end else begin
            irq_stat_q <= irq_stat_q | irq_set;
         end
      end
   end
   assign IRQ = |(irq_stat_q & irq_mask_q);

   //------------------------------------------------------------------------
   // wishbone answer
   //------------------------------------------------------------------------
   // one-cycle ack; unmapped reads return zero, unmapped writes are dropped
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= wr_en | rd_en;
         if (rd_en) begin
            unique case (WB_ADR_I)
               otss_pkg::ADDR_SEL0:     rdat_q <= {16'h0000, sel0_q};
               otss_pkg::ADDR_SEL1:     rdat_q <= {16'h0000, sel1_q};
               otss_pkg::ADDR_INV:      rdat_q <= {16'h0000, inv_q};
               otss_pkg::ADDR_READBACK: rdat_q <= {30'h0, term_q};
               otss_pkg::ADDR_MODE:     rdat_q <= {30'h0, mode_q};
               otss_pkg::ADDR_SIGW:     rdat_q <= {16'h0000, sigw};
               otss_pkg::ADDR_STW1:     rdat_q <= {16'h0000, stw1};
               otss_pkg::ADDR_STW2:     rdat_q <= {16'h0000, stw2};
               otss_pkg::ADDR_IRQ_STAT: rdat_q <= {29'h0, irq_stat_q};
               otss_pkg::ADDR_IRQ_MASK: rdat_q <= {29'h0, irq_mask_q};
               otss_pkg::ADDR_FB_OUT:   rdat_q <= {31'h0, fb_out_q};
               default:                 rdat_q <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdat_q;

endmodule

// ==== dv/otss_checker.sv ====
// checker: handshake, reset state, read ranges and terminal timing of the selector
`timescale 1ns/1ps
module otss_checker (
   input wire logic                   MCLK,
   input wire logic                   RESET,
   input wire logic                   WB_CYC_I,
   input wire logic                   WB_STB_I,
   input wire logic                   WB_WE_I,
   input wire logic [3:0]             WB_SEL_I,
   input wire logic [7:0]             WB_ADR_I,
   input wire logic [31:0]            WB_DAT_I,
   input wire logic [31:0]            WB_DAT_O,
   input wire logic                   WB_ACK_O,
   input wire otss_pkg::otss_status_s STATUS_IN,
   input wire logic                   FIRST_OUTPUT_TERMINAL,
   input wire logic                   SECOND_OUTPUT_TERMINAL,
   input wire logic                   IRQ
);
   //------------------------------------------
   // helpers and properties
   //------------------------------------------
   logic       take;
   logic       t0_q;
   logic [7:0] gap_q;
   assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   // cycles since the first terminal last moved, saturating
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         t0_q  <= 1'b0;
         gap_q <= 8'h00;
      end else begin
         t0_q  <= FIRST_OUTPUT_TERMINAL;
         gap_q <= (FIRST_OUTPUT_TERMINAL != t0_q) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hFF};
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_answer; take |=> WB_ACK_O; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
   property p_reset_idle; $fell(RESET) |-> !FIRST_OUTPUT_TERMINAL && !SECOND_OUTPUT_TERMINAL && !WB_ACK_O && !IRQ; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
   property p_unmapped; take && !WB_WE_I && WB_ADR_I == 8'h2C |=> WB_DAT_O == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_sel0_range; take && !WB_WE_I && WB_ADR_I == 8'h00 |=> WB_DAT_O <= 32'h52; endproperty
   a_sel0_range: assert property (p_sel0_range) else $error("selector out of range");
   property p_inv_range; take && !WB_WE_I && WB_ADR_I == 8'h08 |=> WB_DAT_O <= 32'hFFF; endproperty
   a_inv_range: assert property (p_inv_range) else $error("inversion out of range");
   property p_readback;
      take && !WB_WE_I && WB_ADR_I == 8'h0C |=>
         WB_DAT_O[1:0] == {$past(SECOND_OUTPUT_TERMINAL), $past(FIRST_OUTPUT_TERMINAL)};
   endproperty
   a_readback: assert property (p_readback) else $error("readback differs from terminals");
   property p_tick_gap; FIRST_OUTPUT_TERMINAL != t0_q |-> gap_q >= 8'd60; endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("terminal moved between ticks");
endmodule
bind otss_top otss_checker i_chk (.MCLK(MCLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .STATUS_IN(STATUS_IN), .FIRST_OUTPUT_TERMINAL(FIRST_OUTPUT_TERMINAL),
   .SECOND_OUTPUT_TERMINAL(SECOND_OUTPUT_TERMINAL), .IRQ(IRQ));

// ==== dv/otss_load.sv ====
// partner model: external equipment wired to the two terminals
`timescale 1ns/1ps
module otss_load (
   input  wire logic       clk,
   input  wire logic       term_a,
   input  wire logic       term_b,
   output logic      [1:0] level
);
   // only two terminals exist, nothing is driven back
   always_ff @(posedge clk) begin
      level <= {term_b, term_a};
   end
endmodule

// ==== dv/tb.sv ====
// testbench: register access, terminal routing, inversion and interrupt of the selector
`timescale 1ns/1ps
module tb;
   //------------------------------------------
   // bench state, design and load
   //------------------------------------------
   logic                   mclk, reset, cyc, stb, we, ack, t0, t1, irq;
   logic [3:0]             sel;
   logic [7:0]             adr;
   logic [31:0]            wdat, rdat, d;
   logic [1:0]             lvl;
   otss_pkg::otss_status_s st, z;
   int                     n_fail, comparisons;
   otss_top i_dut (.MCLK(mclk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_SEL_I(sel),
      .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .STATUS_IN(st),
      .FIRST_OUTPUT_TERMINAL(t0), .SECOND_OUTPUT_TERMINAL(t1), .IRQ(irq));
   otss_load i_load (.clk(mclk), .term_a(t0), .term_b(t1), .level(lvl));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic summarize;
      if (n_fail == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // classic single cycle, held until ack is seen at an edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int k;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         n_fail++;
         summarize();
      end
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(d, e);
   endtask
   // one evaluation tick plus load delay
   task automatic tk;
      repeat (102) @(posedge mclk);
   endtask
   function automatic otss_pkg::otss_status_s st_for(input int fn);
      otss_pkg::otss_status_s s;
      s = '0;
      case (fn)
         1: s.nact_lt_nmin = 1'b1;
         2: s.ramp_done = 1'b1;
         3: s.torque_lt_mx = 1'b1;
         4: s.nact_lt_nx = 1'b1;
         5: s.motor_ot_warn = 1'b1;
         6: s.pm_temp_warn = 1'b1;
         7: s.var_signal = 1'b1;
         11: s.motor_sel = 2'h0;
         12: s.motor_sel = 2'h1;
         14: s.motor_sel = 2'h3;
         15: s.fixed_setpoint = 4'h1;
         16: s.fixed_setpoint = 4'h2;
         17: s.fixed_setpoint = 4'h4;
         18: s.fixed_setpoint = 4'h8;
         20: s.nset_eq_nact = 1'b1;
         28: s.spindle_pos_on = 1'b1;
         29: s.warning = 1'b1;
         30: s.vdc_gt_vx = 1'b1;
         31: s.fault_free = 1'b1;
         32: s.ctrl_enable = 1'b1;
         33: s = '{ready: 1'b1, fault_free: 1'b1, default: '0};
         34: s.parking_axis = 1'b1;
         35: s.open_brake = 1'b1;
         36: s.pulses_enabled = 1'b1;
         37: s.pm_current_ok = 1'b1;
         default: s = '0;
      endcase
      return s;
   endfunction
   // select fn on one terminal, then show it on and off
   task automatic route(input logic [7:0] a, input int fn, input logic e);
      logic [1:0] m;
      m = (a == 8'h00) ? 2'h1 : 2'h2;
      st <= '0;
      wb(1'b1, a, 32'(fn));
      st <= st_for(fn);
      tk();
      chk({30'h0, lvl & m}, {30'h0, e ? m : 2'h0});
      st <= z;
      tk();
      chk({30'h0, lvl & m}, 32'h0);
   endtask
   task automatic t_defaults;
      rd(8'h00, 32'h21);
      rd(8'h04, 32'h2);
      rd(8'h08, 32'h0);
      rd(8'h2C, 32'h0);
      st <= st_for(2) | st_for(33);
      tk();
      chk({30'h0, lvl}, 32'h3);
   endtask
   task automatic t_routing;
      int fns[26] = '{0, 1, 2, 3, 4, 5, 6, 7, 11, 12, 14, 15, 16, 17, 18, 20, 28, 29, 30, 31, 32, 33, 34, 35, 36, 37};
      foreach (fns[i]) begin
         route(8'h00, fns[i], fns[i] != 0);
         route(8'h04, fns[i], fns[i] != 0);
      end
   endtask
   task automatic t_modes;
      wb(1'b1, 8'h10, 32'h1);
      route(8'h00, 12, 1'b0);
      route(8'h00, 15, 1'b0);
      route(8'h04, 28, 1'b0);
      route(8'h04, 35, 1'b1);
      wb(1'b1, 8'h10, 32'h0);
   endtask
   task automatic t_invert;
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b1, 8'h04, 32'h0);
      wb(1'b1, 8'h08, 32'h1);
      tk();
      chk({30'h0, lvl}, 32'h1);
      rd(8'h0C, 32'h1);
      wb(1'b1, 8'h08, 32'h2);
      tk();
      chk({30'h0, lvl}, 32'h2);
      rd(8'h0C, 32'h2);
   endtask
   task automatic t_irq;
      rd(8'h20, 32'h3);
      wb(1'b1, 8'h24, 32'h4);
      wb(1'b1, 8'h08, 32'hFFF);
      rd(8'h08, 32'hFFF);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, 8'h08, 32'h1000);
      rd(8'h08, 32'hFFF);
      chk({31'h0, irq}, 32'h1);
      wb(1'b1, 8'h20, 32'h4);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, 8'h24, 32'h0);
      wb(1'b1, 8'h00, 32'h53);
      rd(8'h00, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, 8'h24, 32'h4);
      chk({31'h0, irq}, 32'h1);
      // let the inversion change reach the terminals before clearing all
      tk();
      wb(1'b1, 8'h20, 32'h7);
      rd(8'h20, 32'h0);
      wb(1'b1, 8'h24, 32'h0);
   endtask
   task automatic t_words;
      st <= '{spindle_pos_on: 1'b1, open_loop_torque: 1'b1, open_brake: 1'b1, int_inhibit: 1'b1,
              pm_temp_warn: 1'b1, pm_current_ok: 1'b1, default: '0};
      tk();
      wb(1'b0, 8'h18, 32'h0);
      chk(d & 32'hC000, 32'hC000);
      wb(1'b0, 8'h1C, 32'h0);
      chk(d & 32'h60, 32'h60);
      wb(1'b0, 8'h14, 32'h0);
      chk(d & 32'h480, 32'h480);
      // fieldbus-driven function on the second terminal, mask still all ones
      wb(1'b1, 8'h04, 32'h26);
      tk();
      chk({30'h0, lvl & 2'h2}, 32'h2);
      wb(1'b1, 8'h28, 32'h1);
      rd(8'h28, 32'h1);
      tk();
      chk({30'h0, lvl & 2'h2}, 32'h0);
      wb(1'b1, 8'h10, 32'h2);
      rd(8'h10, 32'h0);
   endtask
   initial begin
      reset = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'h3;
      adr = 8'h00;
      wdat = 32'h0;
      st = '0;
      z = '0;
      z.motor_sel = 2'h2;
      n_fail = 0;
      comparisons = 0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      t_defaults();
      t_routing();
      t_modes();
      t_invert();
      t_irq();
      t_words();
      summarize();
   end
endmodule
